// *** verilog/llt_pkg.sv ***
package llt_pkg;

   localparam int LANES = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_FREQ_MHZ         = 50;
   localparam int TRAIN_TIMEOUT_US     = 500;
   localparam int TRAIN_TIMEOUT_CYCLES = TRAIN_TIMEOUT_US * CLK_FREQ_MHZ;
   localparam int BIT_DIV_CYCLES       = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Training frame: marker, control block, status block, pattern bits
   localparam int          FRAME_BITS   = 32;
   localparam int          FRAME_CNT_W  = 5;
   localparam logic [15:0] FRAME_MARKER = 16'hff00;
   localparam logic [4:0]  FRAME_LAST   = 5'h1f;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_TX_REQ      = 8'h04;
   localparam logic [7:0] REG_TX_STATUS   = 8'h08;
   localparam logic [7:0] REG_SEED_BASE   = 8'h10;
   localparam logic [7:0] REG_LANE_STATUS = 8'h20;
   localparam logic [7:0] REG_PEER_REQ    = 8'h24;
   localparam logic [7:0] REG_PEER_STATUS = 8'h28;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CTRL_ENABLE_BIT   = 0;
   localparam int CTRL_RESTART_BIT  = 1;
   localparam int CTRL_RXDONE_LSB   = 4;
   localparam int LANE_FIELD_STRIDE = 8;
   localparam int STAT_DATA_LSB     = 0;
   localparam int STAT_ACTIVE_LSB   = 4;
   localparam int STAT_TIMEOUT_LSB  = 8;
   localparam int STAT_LOCKED_LSB   = 12;

   localparam logic        CTRL_ENABLE_RESET = 1'b0;
   localparam logic [7:0]  TX_REQ_RESET      = 8'h00;
   localparam logic [5:0]  TX_STATUS_RESET   = 6'h00;
   localparam logic [10:0] SEED_RESET        = 11'h7ff;

   ////////////////////////////////////////////////////////////////////////////
   // Lane training states, one-hot
   localparam int ST_DATA_IDX  = 2;
   localparam int ST_TRAIN_IDX = 1;
   localparam int ST_FAIL_IDX  = 3;

   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'b0001,
      ST_TRAIN = 4'b0010,
      ST_DATA  = 4'b0100,
      ST_FAIL  = 4'b1000
   } llt_state_type;

endpackage : llt_pkg

// *** verilog/llt_lane.sv ***
`timescale 1ns/10ps
`default_nettype none

module llt_lane
   import llt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TRAIN_TIMEOUT_CYCLES
)
(
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_bit_en,
   input  wire logic        i_enable,
   input  wire logic        i_restart,
   input  wire logic        i_rx_done,
   input  wire logic [7:0]  i_tx_req,
   input  wire logic [5:0]  i_tx_status,
   input  wire logic [10:0] i_seed,
   input  wire logic        i_rx_bit,
   output logic             o_tx_bit,
   output logic             o_tx_sof,
   output logic             o_rx_sof,
   output logic             o_data_mode,
   output logic             o_training,
   output logic             o_timeout,
   output logic             o_locked,
   output logic [7:0]       o_peer_req,
   output logic [5:0]       o_peer_status
);

   localparam int TMR_W = $clog2(TIMEOUT_CYCLES + 1);

   typedef struct packed {
      llt_state_type          state;
      logic                   en_seen;
      logic [TMR_W-1:0]       timer;
      logic [10:0]            lfsr;
      logic [FRAME_CNT_W-1:0] tx_cnt;
      logic [FRAME_BITS-1:0]  tx_sr;
      logic                   tx_bit;
      logic                   tx_sof;
      logic [FRAME_BITS-1:0]  rx_sr;
      logic [FRAME_CNT_W-1:0] rx_cnt;
      logic                   aligned;
      logic                   locked;
      logic                   rx_sof;
      logic [7:0]             peer_req;
      logic [5:0]             peer_status;
   } llt_lane_type;

   llt_lane_type r;
   llt_lane_type next_r;

   // Pattern generator, x^11 + x^9 + 1
   function automatic logic [10:0] lfsr_step(input logic [10:0] v);
      return {v[9:0], v[10] ^ v[8]};
   endfunction : lfsr_step

   always_comb
   begin
      logic [FRAME_BITS-1:0] frame;
      logic [FRAME_BITS-1:0] shifted;
      logic                  start;
      frame   = {FRAME_MARKER, i_tx_req, i_tx_status, r.lfsr[1:0]};
      shifted = {r.rx_sr[FRAME_BITS-2:0], i_rx_bit};
      next_r  = r;
      next_r.tx_sof  = 1'b0;
      next_r.rx_sof  = 1'b0;
      next_r.en_seen = i_enable;

      case (r.state)
         ST_IDLE:
            next_r.state = i_enable ? ST_TRAIN : ST_DATA;
         ST_DATA:
            if (i_enable && !r.en_seen)
               next_r.state = ST_TRAIN;
         ST_TRAIN:
            if (r.locked && i_rx_done)
               next_r.state = ST_DATA;
            else if (r.timer == TMR_W'(TIMEOUT_CYCLES - 1))
               next_r.state = ST_FAIL;
         ST_FAIL:
            next_r.state = ST_FAIL;
         default:
            next_r.state = ST_IDLE;
      endcase

      if (!i_enable)
         next_r.state = ST_DATA;
      else if (i_restart)
         next_r.state = ST_TRAIN;

      start = (next_r.state == ST_TRAIN) && ((r.state != ST_TRAIN) || i_restart);
      next_r.timer = (r.state == ST_TRAIN) ? r.timer + 1'b1 : '0;

      // Transmit side: serial frames, MSB first
      if (r.state == ST_TRAIN && i_bit_en)
      begin
         next_r.tx_cnt = r.tx_cnt + 1'b1;
         if (r.tx_cnt == '0)
         begin
            next_r.tx_sof = 1'b1;
            next_r.tx_bit = frame[FRAME_BITS-1];
            next_r.tx_sr  = {frame[FRAME_BITS-2:0], 1'b0};
            next_r.lfsr   = lfsr_step(lfsr_step(r.lfsr));
         end
         else
         begin
            next_r.tx_bit = r.tx_sr[FRAME_BITS-1];
            next_r.tx_sr  = {r.tx_sr[FRAME_BITS-2:0], 1'b0};
         end
      end
      else if (r.state != ST_TRAIN)
      begin
         next_r.tx_bit = 1'b0;
         next_r.tx_cnt = '0;
      end

      // Receive side: hunt for the marker, then check it once per frame
      if (r.state == ST_TRAIN && i_bit_en)
      begin
         next_r.rx_sr  = shifted;
         next_r.rx_cnt = r.rx_cnt + 1'b1;
         if (!r.aligned || r.rx_cnt == FRAME_LAST)
         begin
            if (shifted[FRAME_BITS-1 -: 16] == FRAME_MARKER)
            begin
               next_r.locked      = r.aligned;
               next_r.aligned     = 1'b1;
               next_r.rx_cnt      = '0;
               next_r.rx_sof      = 1'b1;
               next_r.peer_req    = shifted[15:8];
               next_r.peer_status = shifted[7:2];
            end
            else
            begin
               next_r.aligned = 1'b0;
               next_r.locked  = 1'b0;
            end
         end
      end

      if (start)
      begin
         next_r.timer   = '0;
         next_r.lfsr    = i_seed;
         next_r.tx_cnt  = '0;
         next_r.rx_cnt  = '0;
         next_r.aligned = 1'b0;
         next_r.locked  = 1'b0;
      end
      if (!i_enable)
      begin
         next_r.aligned = 1'b0;
         next_r.locked  = 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         r             <= '0;
         r.state       <= ST_IDLE;
         r.lfsr        <= SEED_RESET;
      end
      else
         r <= next_r;
   end

   assign o_tx_bit      = r.tx_bit;
   assign o_tx_sof      = r.tx_sof;
   assign o_rx_sof      = r.rx_sof;
   assign o_data_mode   = r.state[ST_DATA_IDX];
   assign o_training    = r.state[ST_TRAIN_IDX];
   assign o_timeout     = r.state[ST_FAIL_IDX];
   assign o_locked      = r.locked;
   assign o_peer_req    = r.peer_req;
   assign o_peer_status = r.peer_status;

endmodule : llt_lane

`default_nettype wire

// *** verilog/llt_top.sv ***
// Contract
// - With training disabled, lanes skip training and run in data mode.
// - With training enabled, a restart request restarts training from the start, from any state.
// - Each lane's preset request bit goes into transmitted control blocks.
// - Each lane's initialize request bit goes into transmitted control blocks.
// - Each lane's pattern generator is seeded from its own 11-bit seed.
// - Three 2-bit tap update requests per lane go into transmitted control.
// - Three 2-bit tap update statuses per lane go into transmitted status.
// - Data mode flag rises when the lane state machine reaches data mode.
// - Training active flag holds while the lane is training.
// - Timeout flag rises when the lane's training period times out.
// - Received frame start pulses one clock at each received frame.
// - Frame locked flag rises once the receiver synchronizes to frames.
// - The peer's received preset bit is presented per lane.
// - The peer's received initialize bit is presented per lane.
// - The peer's three 2-bit tap update requests are presented per lane.
// - The peer's 2-bit post tap update status is presented per lane.
// - The peer's main and pre tap update statuses are presented too.
// - Transmit frame start pulses one clock at each transmitted frame.
`timescale 1ns/10ps
`default_nettype none

module llt_top
   import llt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TRAIN_TIMEOUT_CYCLES,
   parameter int BIT_DIV        = BIT_DIV_CYCLES
)
(
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_hsel,
   input  wire logic [31:0]      i_haddr,
   input  wire logic [1:0]       i_htrans,
   input  wire logic             i_hwrite,
   input  wire logic [2:0]       i_hsize,
   input  wire logic [31:0]      i_hwdata,
   input  wire logic             i_hready,
   output logic [31:0]           o_hrdata,
   output logic                  o_hreadyout,
   output logic                  o_hresp,
   input  wire logic [LANES-1:0] i_rx_serial,
   output logic [LANES-1:0]      o_tx_serial,
   output logic [LANES-1:0]      o_tx_frame_start_pulse,
   output logic [LANES-1:0]      o_rx_frame_start_pulse,
   output logic [LANES-1:0]      o_lane_data_mode_flag,
   output logic [LANES-1:0]      o_lane_training_active,
   output logic [LANES-1:0]      o_lane_training_timeout,
   output logic [LANES-1:0]      o_lane_frame_locked
);

   typedef struct packed {
      logic                    train_enable_in;
      logic                    train_restart_in;
      logic [LANES-1:0]        receiver_done_in;
      logic [LANES-1:0][7:0]   tx_req;
      logic [LANES-1:0][5:0]   tx_status;
      logic [LANES-1:0][10:0]  pattern_seed;
      logic [LANES-1:0]        rx_meta;
      logic [LANES-1:0]        rx_sync;
      logic [7:0]              div;
      logic                    bit_en;
      logic                    wr_pend;
      logic [7:0]              wr_addr;
      logic [31:0]             hrdata;
      logic                    hreadyout;
   } llt_top_type;

   llt_top_type r;
   llt_top_type next_r;

   logic [LANES-1:0]       lane_tx_bit;
   logic [LANES-1:0]       lane_tx_sof;
   logic [LANES-1:0]       lane_rx_sof;
   logic [LANES-1:0]       lane_data;
   logic [LANES-1:0]       lane_train;
   logic [LANES-1:0]       lane_fail;
   logic [LANES-1:0]       lane_lock;
   logic [LANES-1:0][7:0]  peer_req;
   logic [LANES-1:0][5:0]  peer_status;

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode; unmapped offsets read as zero
   function automatic logic [31:0] reg_read(input llt_top_type s, input logic [7:0] addr);
      logic [31:0] v;
      v = '0;
      for (int l = 0; l < LANES; l++)
      begin
         case (addr)
            REG_CTRL:
            begin
               v[CTRL_ENABLE_BIT]     = s.train_enable_in;
               v[CTRL_RXDONE_LSB + l] = s.receiver_done_in[l];
            end
            REG_TX_REQ:
               v[l*LANE_FIELD_STRIDE +: 8] = s.tx_req[l];
            REG_TX_STATUS:
               v[l*LANE_FIELD_STRIDE +: 6] = s.tx_status[l];
            REG_LANE_STATUS:
            begin
               v[STAT_DATA_LSB + l]    = lane_data[l];
               v[STAT_ACTIVE_LSB + l]  = lane_train[l];
               v[STAT_TIMEOUT_LSB + l] = lane_fail[l];
               v[STAT_LOCKED_LSB + l]  = lane_lock[l];
            end
            REG_PEER_REQ:
               v[l*LANE_FIELD_STRIDE +: 8] = peer_req[l];
            REG_PEER_STATUS:
               v[l*LANE_FIELD_STRIDE +: 6] = peer_status[l];
            default:
               if (addr == REG_SEED_BASE + 8'(4 * l))
                  v[10:0] = s.pattern_seed[l];
         endcase
      end
      return v;
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave, bit-rate divider and link input synchronizers
   always_comb
   begin
      logic accept;
      accept = i_hsel && i_htrans[1] && i_hready;
      next_r = r;
      next_r.hreadyout        = 1'b1;
      next_r.train_restart_in = 1'b0;

      // Serial lines come from the link partner, outside this clock
      next_r.rx_meta = i_rx_serial;
      next_r.rx_sync = r.rx_meta;

      next_r.bit_en = (r.div == 8'(BIT_DIV - 1));
      next_r.div    = next_r.bit_en ? 8'h00 : r.div + 8'h01;

      // Write lands in the data phase of the transfer
      if (r.wr_pend)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            case (r.wr_addr)
               REG_CTRL:
               begin
                  next_r.train_enable_in     = i_hwdata[CTRL_ENABLE_BIT];
                  next_r.train_restart_in    = i_hwdata[CTRL_RESTART_BIT];
                  next_r.receiver_done_in[l] = i_hwdata[CTRL_RXDONE_LSB + l];
               end
               REG_TX_REQ:
                  next_r.tx_req[l] = i_hwdata[l*LANE_FIELD_STRIDE +: 8];
               REG_TX_STATUS:
                  next_r.tx_status[l] = i_hwdata[l*LANE_FIELD_STRIDE +: 6];
               default:
                  if (r.wr_addr == REG_SEED_BASE + 8'(4 * l))
                     next_r.pattern_seed[l] = i_hwdata[10:0];
            endcase
         end
      end

      next_r.wr_pend = accept && i_hwrite;
      next_r.wr_addr = i_haddr[7:0];
      // Read sees any write finishing this cycle, so back-to-back is coherent
      next_r.hrdata  = (accept && !i_hwrite) ? reg_read(next_r, i_haddr[7:0]) : 32'h00000000;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         r                 <= '0;
         r.train_enable_in <= CTRL_ENABLE_RESET;
         r.tx_req          <= {LANES{TX_REQ_RESET}};
         r.tx_status       <= {LANES{TX_STATUS_RESET}};
         r.pattern_seed    <= {LANES{SEED_RESET}};
      end
      else
         r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lanes share nothing but control fan-out
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      llt_lane #(
         .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
      ) u_lane (
         .i_clk         (i_clk),
         .i_reset       (i_reset),
         .i_bit_en      (r.bit_en),
         .i_enable      (r.train_enable_in),
         .i_restart     (r.train_restart_in),
         .i_rx_done     (r.receiver_done_in[g]),
         .i_tx_req      (r.tx_req[g]),
         .i_tx_status   (r.tx_status[g]),
         .i_seed        (r.pattern_seed[g]),
         .i_rx_bit      (r.rx_sync[g]),
         .o_tx_bit      (lane_tx_bit[g]),
         .o_tx_sof      (lane_tx_sof[g]),
         .o_rx_sof      (lane_rx_sof[g]),
         .o_data_mode   (lane_data[g]),
         .o_training    (lane_train[g]),
         .o_timeout     (lane_fail[g]),
         .o_locked      (lane_lock[g]),
         .o_peer_req    (peer_req[g]),
         .o_peer_status (peer_status[g])
      );
   end

   assign o_hrdata                = r.hrdata;
   assign o_hreadyout             = r.hreadyout;
   assign o_hresp                 = 1'b0;
   assign o_tx_serial             = lane_tx_bit;
   assign o_tx_frame_start_pulse  = lane_tx_sof;
   assign o_rx_frame_start_pulse  = lane_rx_sof;
   assign o_lane_data_mode_flag   = lane_data;
   assign o_lane_training_active  = lane_train;
   assign o_lane_training_timeout = lane_fail;
   assign o_lane_frame_locked     = lane_lock;

endmodule : llt_top

`default_nettype wire

// *** verif/llt_peer_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module llt_peer_model
   import llt_pkg::*;
#(
   parameter int BIT_DIV = 4
)
(
   input  wire logic             i_clk,
   input  wire logic [LANES-1:0] i_en,
   input  wire logic [31:0]      i_req,
   input  wire logic [31:0]      i_stat,
   output var  logic [LANES-1:0] o_line
);
   int          div = 0;
   logic [4:0]  idx = 5'h0;
   logic [31:0] frame;

   initial o_line = '0;

   // A silent lane toggles every bit, so it shows neither a stale level nor a marker
   always @(posedge i_clk)
   begin
      div <= (div == BIT_DIV - 1) ? 0 : div + 1;
      if (div == 0)
      begin
         idx <= idx + 5'h1;
         for (int l = 0; l < LANES; l++)
         begin
            // Pattern bits end in 1 so no false marker forms inside a frame
            frame = {FRAME_MARKER, i_req[8*l +: 8], i_stat[8*l +: 6], 2'b01};
            o_line[l] <= i_en[l] ? frame[5'h1f - idx] : ~o_line[l];
         end
      end
   end
endmodule : llt_peer_model

`default_nettype wire

// *** verif/llt_top_props.sv ***
`timescale 1ns/10ps
`default_nettype none

module llt_top_props
   import llt_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TRAIN_TIMEOUT_CYCLES
)
(
   input wire logic             i_clk,
   input wire logic             i_reset,
   input wire logic             i_hsel,
   input wire logic [31:0]      i_haddr,
   input wire logic [1:0]       i_htrans,
   input wire logic             i_hwrite,
   input wire logic [31:0]      i_hwdata,
   input wire logic             i_hready,
   input wire logic [31:0]      o_hrdata,
   input wire logic             o_hreadyout,
   input wire logic             o_hresp,
   input wire logic [LANES-1:0] o_tx_frame_start_pulse,
   input wire logic [LANES-1:0] o_rx_frame_start_pulse,
   input wire logic [LANES-1:0] o_lane_data_mode_flag,
   input wire logic [LANES-1:0] o_lane_training_active,
   input wire logic [LANES-1:0] o_lane_training_timeout
);
   default clocking dc @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   // Lane 3 is one of the two lanes (2 and 3) that the bench starves of frames
   int train_cnt;

   always_ff @(posedge i_clk)
   begin
      if (i_reset || !o_lane_training_active[3])
         train_cnt <= 0;
      else
         train_cnt <= train_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_ctrl_write;
      i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr[7:0] == REG_CTRL ##1 1'b1;
   endsequence

   chk_rx_sof_pulse: assert property (|o_rx_frame_start_pulse |=> o_rx_frame_start_pulse == '0)
      else $error("receive frame start longer than one cycle");
   chk_tx_sof_pulse: assert property (|o_tx_frame_start_pulse |=> o_tx_frame_start_pulse == '0)
      else $error("transmit frame start longer than one cycle");
   chk_tx_sof_training: assert property ((o_tx_frame_start_pulse & ~$past(o_lane_training_active)) == '0)
      else $error("transmit frame outside training");
   chk_rx_sof_training: assert property ((o_rx_frame_start_pulse & ~$past(o_lane_training_active)) == '0)
      else $error("receive frame outside training");
   chk_mode_exclusive: assert property ((o_lane_data_mode_flag & o_lane_training_active) == '0)
      else $error("data mode and training together");
   chk_fail_exclusive: assert property
      ((o_lane_training_timeout & (o_lane_data_mode_flag | o_lane_training_active)) == '0)
      else $error("timeout flag with another state");
   chk_fail_timing: assert property ($rose(o_lane_training_timeout[3]) |->
      train_cnt >= TIMEOUT_CYCLES - 3 && train_cnt <= TIMEOUT_CYCLES + 2)
      else $error("timeout after wrong training length");
   chk_stop_mission: assert property
      (s_ctrl_write ##0 !i_hwdata[0] |-> ##[1:3] o_lane_data_mode_flag == 4'hf)
      else $error("disable did not give data mode");
   chk_restart_train: assert property
      (s_ctrl_write ##0 i_hwdata[1:0] == 2'b11 |-> ##[1:3] o_lane_training_active == 4'hf)
      else $error("restart did not start training");
   chk_bus_ready: assert property (!$past(i_reset) |-> o_hreadyout)
      else $error("bus wait state inserted");
   chk_bus_okay: assert property (o_hresp == 1'b0)
      else $error("bus error response");
   chk_rdata_idle: assert property (!(i_hsel && i_hready && i_htrans[1] && !i_hwrite) |=> o_hrdata == '0)
      else $error("read data outside read data phase");
endmodule : llt_top_props

bind llt_top llt_top_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props
(
   .i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_tx_frame_start_pulse(o_tx_frame_start_pulse),
   .o_rx_frame_start_pulse(o_rx_frame_start_pulse), .o_lane_data_mode_flag(o_lane_data_mode_flag),
   .o_lane_training_active(o_lane_training_active), .o_lane_training_timeout(o_lane_training_timeout)
);

`default_nettype wire

// *** verif/llt_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module llt_top_tb;
   import llt_pkg::*;

   localparam int          TMO  = 2000;
   localparam int          BDIV = 4;
   localparam logic [31:0] TXQ  = 32'h9c63_a5e1;
   localparam logic [31:0] TXS  = 32'h001b_2d36;
   localparam logic [31:0] PRQ  = 32'h5ac3_3ca6;
   localparam logic [31:0] PST  = 32'h0024_3f09;

   logic             i_clk   = 1'b0;
   logic             i_reset = 1'b1;
   logic [31:0]      haddr   = '0;
   logic [31:0]      hwdata  = '0;
   logic [1:0]       htrans  = '0;
   logic             hwrite  = 1'b0;
   logic [LANES-1:0] peer_en = '0;
   logic [31:0]      hrdata, rdata;
   logic             hreadyout, hresp;
   logic [LANES-1:0] rx_line, tx_line, tx_sof, rx_sof, st_data, st_train, st_fail, st_lock;
   int               num_errors  = 0;
   int               checks_done = 0;

   always #10 i_clk = ~i_clk;

   llt_top #(.TIMEOUT_CYCLES(TMO), .BIT_DIV(BDIV)) uut
   (
      .i_clk(i_clk), .i_reset(i_reset), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_rx_serial(rx_line), .o_tx_serial(tx_line), .o_tx_frame_start_pulse(tx_sof),
      .o_rx_frame_start_pulse(rx_sof), .o_lane_data_mode_flag(st_data),
      .o_lane_training_active(st_train), .o_lane_training_timeout(st_fail), .o_lane_frame_locked(st_lock)
   );

   llt_peer_model #(.BIT_DIV(BDIV)) peer
   (
      .i_clk(i_clk), .i_en(peer_en), .i_req(PRQ), .i_stat(PST), .o_line(rx_line)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         num_errors++;
         wrap_up();
      end
   endtask : wait_ready

   // Address phase held until ready, then data phase held until ready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, rdata);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(a, 1'b0, 32'h0, rdata);
      chk(nm, rdata, e);
   endtask : rc

   // Polls lane status; the flag ports must agree with the register
   task automatic wait_stat(input logic [31:0] e, input int lim);
      int n;
      n = 0;
      do
      begin
         bus(REG_LANE_STATUS, 1'b0, 32'h0, rdata);
         n++;
      end
      while (rdata !== e && n < lim);
      chk("lane status", rdata, e);
      chk("lane flags", {16'h0, st_lock, st_fail, st_train, st_data}, e);
   endtask : wait_stat

   task automatic grab(input int l, output logic [31:0] f);
      int n;
      n = 0;
      while (tx_sof[l] !== 1'b1 && n < 400)
      begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 400)
      begin
         num_errors++;
         wrap_up();
      end
      for (int i = 31; i >= 0; i--)
      begin
         if (i < 31)
            repeat (BDIV) @(posedge i_clk);
         f[i] = tx_line[l];
      end
   endtask : grab

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] f;
      int          n;
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      rc(REG_CTRL, 32'h0, "ctrl");
      rc(REG_SEED_BASE + 8'h0c, 32'h7ff, "seed 3");
      wait_stat(32'h0000_000f, 8);
      wr(8'h3c, 32'hffff_ffff);
      rc(8'h3c, 32'h0, "unmapped");
      wr(REG_TX_REQ, TXQ);
      wr(REG_TX_STATUS, TXS);
      wr(REG_SEED_BASE, 32'h155);
      rc(REG_TX_REQ, TXQ, "tx req");
      rc(REG_TX_STATUS, TXS, "tx status");
      rc(REG_SEED_BASE, 32'h155, "seed 0");
      peer_en <= 4'hf;
      wr(REG_CTRL, 32'h3);
      // First frame after the start carries the low bits of lane 0's own seed 0x155
      grab(0, f);
      chk("first frame", f, {FRAME_MARKER, TXQ[7:0], TXS[5:0], 2'b01});
      wait_stat(32'h0000_f0f0, 600);
      // Locked lane: exactly one receive start in one frame time
      n = 0;
      repeat (BDIV * FRAME_BITS) @(posedge i_clk) n += rx_sof[0];
      chk("rx frame starts", n, 32'h1);
      for (int l = 0; l < LANES; l++)
      begin
         grab(l, f);
         chk("tx frame", {f[31:2], 2'b00}, {FRAME_MARKER, TXQ[8*l +: 8], TXS[8*l +: 6], 2'b00});
      end
      rc(REG_PEER_REQ, PRQ, "peer req");
      rc(REG_PEER_STATUS, PST, "peer status");
      wr(REG_CTRL, 32'hf1);
      wait_stat(32'h0000_f00f, 20);
      peer_en <= 4'h3;
      wr(REG_CTRL, 32'hf3);
      rc(REG_CTRL, 32'hf1, "ctrl");
      rc(REG_LANE_STATUS, 32'h0000_00f0, "restarted");
      wait_stat(32'h0000_3c03, 2000);
      wr(REG_CTRL, 32'h0);
      wait_stat(32'h0000_000f, 8);
      wrap_up();
   end
endmodule : llt_top_tb

`default_nettype wire
